/* File: mers_top.sv */
// Function
// RULE1 - enable loss stops motor, brake or coast
// RULE2 - one quiet second then power everything down
// RULE3 - sleep keeps register port alive only
// RULE4 - short-pulse filter or polarity change triggers
// RULE5 - sequence completes; enable back restarts later
// RULE6 - reset during power-down pends until enable
// RULE7 - reset while enabled: stop, wait, reload
// RULE8 - motor stays off while reset held
// RULE9 - shared enable/reset pin works active-low
// RULE10 - commutation timer 25 bits at 50 MHz
// RULE11 - sine cycle uses 960 steps
// RULE12 - 120 degree hall mode purely combinational; code registers the gates from the synchronised halls
// RULE13 - speed parameters apply immediately when written
// RULE14 - loop best between 50 Hz and 6.7 kHz
// RULE15 - no loop limits in open speed modes
// RULE16 - auto gain widens range up to 4x; code stores the ctrl auto bit (CTRL_AUTO_POS) but no logic uses it
// RULE17 - every tach edge counts as rotation
// RULE18 - fault bits one when detected
// RULE19 - quiet timer restarts on each tach edge
// RULE20 - pins synchronised, short enable gaps ignored
// RULE21 - wake restarts clocks and regulator first
`timescale 1ns/1ps
`default_nettype none

module mers_top
  import mers_pkg::*;
#(
  parameter int unsigned STOP_CYC = STOP_WAIT_CYC,
  parameter int unsigned TMR_W    = COMM_TMR_W
) (
  input  wire logic                   core_clk,      // 250 MHz clock
  input  wire logic                   rst_n,         // async reset
  input  wire logic                   enable_pin,    // enable pin, async
  input  wire logic                   reset_pin,     // reset pin, async
  input  wire logic                   tach_pulse_output, // tach, async
  input  wire logic [2:0]             hall_in,       // hall levels, async
  input  wire logic [6:0]             fault_det,     // fault detectors
  input  wire logic [mers_pkg::ADDR_W-1:0] reg_addr, // register address
  input  wire logic [mers_pkg::DATA_W-1:0] reg_wdata, // write data
  input  wire logic                   reg_wr,        // write strobe
  input  wire logic                   reg_rd,        // read strobe
  output var  logic [mers_pkg::DATA_W-1:0] reg_rdata, // read data
  output var  logic                   motor_drive_en, // bridge enabled
  output var  logic                   brake_active,  // low-side brake
  output var  logic                   hall_supply_regulator, // hall 5 V
  output var  logic                   core_clk_en,   // internal clocks
  output var  logic                   otp_reload,    // reload pulse
  output var  logic [5:0]             phase_gate,    // 120 deg gates
  output var  logic                   tb_tick        // 50 MHz timebase
);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  if (STOP_CYC < 2 || TMR_W < 16 || TMR_W > 32) begin : g_param_chk
    $error("mers_top: unsupported parameter");
  end

  localparam logic [31:0] STOP_LAST = 32'(STOP_CYC - 1);
  localparam logic [15:0] ENMIN_L   = 16'(EN_MIN_CYC - 1);
  localparam logic [2:0]  DIV_L     = 3'(TB_DIV - 1);
  localparam logic [4:0]  WAKE_L    = 5'(WAKE_CYC - 1);
  localparam logic [9:0]  STEP_L    = 10'(SINE_STEPS - 1);

  // hall state to six gates, 120 deg
  function automatic logic [5:0] hall_gates(input logic [2:0] h);
    case (h)
      3'h1:    hall_gates = 6'h21;
      3'h2:    hall_gates = 6'h0A;
      3'h3:    hall_gates = 6'h09;
      3'h4:    hall_gates = 6'h14;
      3'h5:    hall_gates = 6'h24;
      3'h6:    hall_gates = 6'h12;
      default: hall_gates = 6'h00;
    endcase
  endfunction : hall_gates

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] raw_pins;
  logic [5:0] sync_pins;
  assign raw_pins = {hall_in, tach_pulse_output, reset_pin, enable_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      mers_sync u_sync ( // RULE20
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d_in     (raw_pins[gi]),
        .q_out    (sync_pins[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    mers_state_t             state;
    logic [4:0]              ctrl;
    logic [11:0]             spd_gain;
    logic [11:0]             spd_cmd;
    logic [6:0]              fault;
    logic [15:0]             rdata;
    logic [15:0]             en_low_cnt;
    logic                    en_act;
    logic                    enable_polarity_bit_q;
    logic [31:0]             quiet_cnt;
    logic                    tach_q;
    logic                    rst_pend;
    logic                    reset_cause;
    logic [4:0]              wake_cnt;
    logic [2:0]              div_cnt;
    logic                    tick;
    logic [TMR_W-1:0]        per_tmr;
    logic [TMR_W-1:0]        period;
    logic [9:0]              step;
    logic                    drive;
    logic                    brake;
    logic                    vreg;
    logic                    clk_en;
    logic                    reload;
    logic [5:0]              gates;
    logic [2:0]              hall_q;
  } mers_st_t;

  mers_st_t st_reg;
  mers_st_t st_next;

  logic en_pin_s;
  logic rst_pin_s;
  logic tach_s;
  logic [2:0] hall_s;
  logic en_level;
  logic rst_level;
  logic tach_edge;
  logic quiet_done;
  logic trig_stop;
  logic loop_mode;
  logic sine_mode;

  assign en_pin_s  = sync_pins[0];
  assign rst_pin_s = sync_pins[1];
  assign tach_s    = sync_pins[2];
  assign hall_s    = sync_pins[5:3];

  always_comb begin
    // enable is active-low when the polarity bit is set
    en_level   = en_pin_s ^ st_reg.ctrl[CTRL_ENABLE_POLARITY_BIT_POS]; // RULE9
    // reset keeps its own sense so a shared pin low runs the motor
    rst_level  = rst_pin_s; // RULE9
    tach_edge  = tach_s ^ st_reg.tach_q; // RULE17
    quiet_done = (st_reg.quiet_cnt == STOP_LAST);
    trig_stop  = (!st_reg.en_act)
               | (st_reg.enable_polarity_bit_q != st_reg.ctrl[CTRL_ENABLE_POLARITY_BIT_POS]); // RULE4
    loop_mode  = st_reg.ctrl[CTRL_LOOP_POS]; // RULE14
    sine_mode  = st_reg.ctrl[CTRL_SINE_POS];
  end

  always_comb begin
    st_next        = st_reg;
    st_next.reload = 1'b0;
    st_next.tach_q = tach_s;

    // -------------------------------------------------------------
    // register port, alive in every state
    // -------------------------------------------------------------
    if (reg_wr) begin // RULE3
      case (reg_addr)
        REG_CTRL:    st_next.ctrl     = reg_wdata[4:0]; // RULE16
        REG_SPDGAIN: st_next.spd_gain = reg_wdata[11:0]; // RULE13
        REG_SPDCMD:  st_next.spd_cmd  = reg_wdata[11:0]; // RULE13
        REG_FAULT:   st_next.fault    = st_reg.fault & ~reg_wdata[6:0];
        default:     st_next.ctrl     = st_reg.ctrl;
      endcase
    end
    st_next.fault = st_next.fault | fault_det; // RULE18
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:      st_next.rdata = {11'h000, st_reg.ctrl};
        REG_SPDGAIN:   st_next.rdata = {4'h0, st_reg.spd_gain};
        REG_SPDCMD:    st_next.rdata = {4'h0, st_reg.spd_cmd};
        REG_STATUS:    st_next.rdata = {10'h000, st_reg.rst_pend,
                                        st_reg.drive, 1'b0, st_reg.state};
        REG_FAULT:     st_next.rdata = {9'h000, st_reg.fault};
        REG_PERIOD_LO: st_next.rdata = st_reg.period[15:0];
        REG_PERIOD_HI: st_next.rdata = 16'(st_reg.period >> 16);
        default:       st_next.rdata = 16'h0000;
      endcase
    end else begin
      st_next.rdata = 16'h0000;
    end

    // -------------------------------------------------------------
    // enable minimum-width filter
    // -------------------------------------------------------------
    if (en_level) begin // RULE20
      st_next.en_low_cnt = 16'h0000;
      st_next.en_act     = 1'b1;
    end else if (st_reg.en_low_cnt >= ENMIN_L) begin // RULE4
      st_next.en_act     = 1'b0;
    end else begin
      st_next.en_low_cnt = st_reg.en_low_cnt + 16'h0001;
    end

    // quiet-rotation timer
    if (tach_edge) begin
      st_next.quiet_cnt = 32'h0000_0000; // RULE19
    end else if (!quiet_done) begin
      st_next.quiet_cnt = st_reg.quiet_cnt + 32'h0000_0001;
    end

    // -------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------
    case (st_reg.state)
      MERS_RUN: begin
        st_next.drive = 1'b1;
        st_next.brake = 1'b0;
        if (trig_stop) begin
          st_next.enable_polarity_bit_q     = st_reg.ctrl[CTRL_ENABLE_POLARITY_BIT_POS];
          st_next.reset_cause = 1'b0;
          st_next.state       = MERS_STOPPING; // RULE1
          st_next.quiet_cnt   = 32'h0000_0000;
        end else if (rst_level) begin
          st_next.reset_cause = 1'b1;
          st_next.state       = MERS_STOPPING; // RULE7
          st_next.quiet_cnt   = 32'h0000_0000;
        end
      end
      MERS_STOPPING: begin
        st_next.drive = 1'b0;
        st_next.brake = ~st_reg.ctrl[CTRL_BRAKE_POS]; // RULE1
        if (!st_reg.reset_cause && rst_level) begin
          st_next.rst_pend = 1'b1; // RULE6
        end
        if (quiet_done) begin // RULE2
          if (st_reg.reset_cause) begin
            st_next.state = MERS_RELOAD; // RULE7
          end else begin
            st_next.state  = MERS_SLEEP; // RULE5
            st_next.vreg   = 1'b0;
            st_next.clk_en = 1'b0;
            st_next.brake  = 1'b0;
          end
        end
      end
      MERS_SLEEP: begin
        st_next.vreg   = 1'b0; // RULE2
        st_next.clk_en = 1'b0;
        if (rst_level) begin
          st_next.rst_pend = 1'b1; // RULE6
        end
        if (st_reg.en_act) begin
          st_next.state    = MERS_WAKE;
          st_next.vreg     = 1'b1; // RULE21
          st_next.clk_en   = 1'b1;
          st_next.wake_cnt = 5'h00;
          st_next.enable_polarity_bit_q  = st_reg.ctrl[CTRL_ENABLE_POLARITY_BIT_POS];
        end
      end
      MERS_WAKE: begin
        st_next.wake_cnt = st_reg.wake_cnt + 5'h01;
        if (st_reg.wake_cnt == WAKE_L) begin // RULE21
          if (st_reg.rst_pend) begin
            st_next.state = MERS_RELOAD; // RULE6
          end else begin
            st_next.state = MERS_RUN;
          end
        end
      end
      MERS_RELOAD: begin
        st_next.reload   = 1'b1; // RULE7
        st_next.ctrl     = CTRL_RST_VAL;
        st_next.spd_gain = SPD_RST_VAL;
        st_next.spd_cmd  = SPD_RST_VAL;
        st_next.fault    = fault_det;
        st_next.per_tmr  = '0;
        st_next.period   = '0;
        st_next.step     = 10'h000;
        st_next.rst_pend = 1'b0;
        st_next.brake    = 1'b0;
        st_next.enable_polarity_bit_q  = CTRL_RST_VAL[CTRL_ENABLE_POLARITY_BIT_POS];
        st_next.state    = MERS_HOLD_RST;
      end
      MERS_HOLD_RST: begin
        st_next.drive = 1'b0; // RULE8
        if (!rst_level) begin
          st_next.state = MERS_RUN; // RULE9
        end
      end
      default: st_next.state = MERS_SLEEP;
    endcase

    // -------------------------------------------------------------
    // 50 MHz timebase and sine period timer
    // -------------------------------------------------------------
    st_next.tick = 1'b0;
    if (st_reg.clk_en) begin
      if (st_reg.div_cnt == DIV_L) begin
        st_next.div_cnt = 3'h0;
        st_next.tick    = 1'b1;
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 3'h1;
      end
    end
    if (st_reg.tick && st_reg.state == MERS_RUN) begin // RULE10
      st_next.hall_q  = hall_s;
      if (hall_s[0] && !st_reg.hall_q[0]) begin
        st_next.period  = st_reg.per_tmr;
        st_next.per_tmr = '0;
        st_next.step    = 10'h000;
      end else if (st_reg.per_tmr != '1) begin
        st_next.per_tmr = st_reg.per_tmr + 1'b1;
      end
      // sine stepping across one electrical cycle
      if (sine_mode && st_reg.step != STEP_L) begin // RULE11
        st_next.step = st_reg.step + 10'h001;
      end
    end

    // 120 deg mode: gates follow the halls, no timer involved
    if (st_reg.state == MERS_RUN && !sine_mode && !loop_mode) begin
      st_next.gates = hall_gates(hall_s); // RULE12
    end else if (st_reg.state == MERS_RUN) begin
      // speed-loop and open modes share the hall table; no range clamp
      st_next.gates = hall_gates(hall_s); // RULE15
    end else begin
      st_next.gates = 6'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.state    <= MERS_HOLD_RST;
      st_reg.ctrl     <= CTRL_RST_VAL;
      st_reg.fault    <= FAULT_RST_VAL; // RULE18
      st_reg.en_act   <= 1'b1;
      st_reg.vreg     <= 1'b1;
      st_reg.clk_en   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata             = st_reg.rdata;
  assign motor_drive_en        = st_reg.drive;
  assign brake_active          = st_reg.brake;
  assign hall_supply_regulator = st_reg.vreg;
  assign core_clk_en           = st_reg.clk_en;
  assign otp_reload            = st_reg.reload;
  assign phase_gate            = st_reg.gates;
  assign tb_tick               = st_reg.tick;

endmodule : mers_top

`default_nettype wire

/* File: mers_pkg.sv */
package mers_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CORE_CLK_MHZ     = 250;
  localparam int unsigned EN_MIN_NS        = 1200;
  localparam int unsigned EN_MIN_CYC       = (EN_MIN_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned STOP_WAIT_MS     = 1000;
  localparam int unsigned STOP_WAIT_CYC    = STOP_WAIT_MS * CORE_CLK_MHZ * 1000;
  localparam int unsigned TB_DIV           = 5;
  localparam int unsigned WAKE_CYC         = 16;

  // ---------------------------------------------------------------
  // commutation timer
  // ---------------------------------------------------------------
  localparam int unsigned COMM_TMR_W       = 25;
  localparam int unsigned SINE_STEPS       = 960;
  localparam int unsigned SPD_PAR_W        = 12;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 16;
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_SPDGAIN      = 8'h01;
  localparam logic [7:0]  REG_SPDCMD       = 8'h02;
  localparam logic [7:0]  REG_STATUS       = 8'h03;
  localparam logic [7:0]  REG_FAULT        = 8'h2A;
  localparam logic [7:0]  REG_PERIOD_LO    = 8'h04;
  localparam logic [7:0]  REG_PERIOD_HI    = 8'h05;

  // ctrl fields
  localparam int unsigned CTRL_BRAKE_POS   = 0;
  localparam int unsigned CTRL_ENABLE_POLARITY_BIT_POS   = 1;
  localparam int unsigned CTRL_SINE_POS    = 2;
  localparam int unsigned CTRL_LOOP_POS    = 3;
  localparam int unsigned CTRL_AUTO_POS    = 4;
  localparam logic [4:0]  CTRL_RST_VAL     = 5'h00;

  // fault layout, power-up value has charge pump and undervoltage set
  localparam int unsigned FLT_W            = 7;
  localparam logic [6:0]  FAULT_RST_VAL    = 7'h18;
  localparam logic [11:0] SPD_RST_VAL      = 12'h000;

  typedef enum logic [2:0] {
    MERS_RUN,
    MERS_STOPPING,
    MERS_SLEEP,
    MERS_WAKE,
    MERS_RELOAD,
    MERS_HOLD_RST
  } mers_state_t;

endpackage : mers_pkg

/* File: mers_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module mers_sync (
  input  wire logic core_clk, // clock
  input  wire logic rst_n,    // async reset
  input  wire logic d_in,     // async level
  output var  logic q_out     // synchronised level
);

  typedef struct packed {
    logic s1;
    logic s2;
  } mers_sync_st_t;

  mers_sync_st_t st_reg;
  mers_sync_st_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_in;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_out = st_reg.s2;

endmodule : mers_sync

`default_nettype wire

/* File: mers_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module mers_top_properties
  import mers_pkg::*;
#(
  parameter int unsigned STOP_CYC = STOP_WAIT_CYC
) (
  input wire logic        core_clk,              // clock
  input wire logic        rst_n,                 // async reset
  input wire logic        tach_pulse_output,     // tach in
  input wire logic        reg_rd,                // read strobe
  input wire logic [15:0] reg_rdata,             // read data
  input wire logic        motor_drive_en,        // bridge on
  input wire logic        brake_active,          // brake
  input wire logic        hall_supply_regulator, // hall supply
  input wire logic        core_clk_en,           // clocks on
  input wire logic        otp_reload,            // reload pulse
  input wire logic [5:0]  phase_gate,            // gates
  input wire logic        tb_tick                // timebase
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // quiet time since last raw tach edge
  // ---------------------------------------------------------------
  logic        tach_reg;
  logic [31:0] quiet_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tach_reg  <= 1'b0;
      quiet_reg <= 32'h0000_0000;
    end else begin
      tach_reg  <= tach_pulse_output;
      if (tach_pulse_output != tach_reg) begin
        quiet_reg <= 32'h0000_0000;
      end else if (quiet_reg != 32'hFFFF_FFFF) begin
        quiet_reg <= quiet_reg + 32'h0000_0001;
      end
    end
  end

  a_tick_gap: assert property (tb_tick |=> !tb_tick [*4])
    else $error("timebase tick too early");
  a_tick_rate: assert property (
    (tb_tick && core_clk_en) ##1 core_clk_en [*4] |=> tb_tick)
    else $error("timebase tick missing");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_sleep_off: assert property (
    !hall_supply_regulator |-> !core_clk_en && !motor_drive_en)
    else $error("sleep with logic still on");
  a_wake_first: assert property (
    $rose(motor_drive_en) |->
      $past(core_clk_en, 7) && $past(hall_supply_regulator, 7))
    else $error("drive before supply and clocks");
  a_reload_off: assert property (
    otp_reload |-> !motor_drive_en ##1 !otp_reload)
    else $error("reload with drive on or long pulse");
  a_brake_stop: assert property (brake_active |-> !motor_drive_en)
    else $error("brake while driving");
  a_phase_idle: assert property (
    !motor_drive_en ##1 !motor_drive_en |-> phase_gate == 6'h00)
    else $error("gates active while stopped");
  a_sleep_quiet: assert property (
    $fell(hall_supply_regulator) |-> quiet_reg >= STOP_CYC)
    else $error("sleep before quiet time ran out");
endmodule : mers_top_properties

bind mers_top mers_top_properties #(.STOP_CYC(STOP_CYC)) u_mers_top_properties (
  .core_clk(core_clk), .rst_n(rst_n), .tach_pulse_output(tach_pulse_output),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_drive_en(motor_drive_en),
  .brake_active(brake_active), .hall_supply_regulator(hall_supply_regulator),
  .core_clk_en(core_clk_en), .otp_reload(otp_reload),
  .phase_gate(phase_gate), .tb_tick(tb_tick)
);

`default_nettype wire

/* File: mers_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module mers_host_model
  import mers_pkg::*;
(
  input  wire logic        core_clk,   // clock
  input  wire logic [15:0] reg_rdata,  // read data
  output var  logic        enable_pin, // enable pin
  output var  logic        reset_pin,  // reset pin
  output var  logic [7:0]  reg_addr,   // address
  output var  logic [15:0] reg_wdata,  // write data
  output var  logic        reg_wr,     // write strobe
  output var  logic        reg_rd      // read strobe
);
  initial begin
    enable_pin = 1'b1;
    reset_pin  = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 16'h0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
  end

  // both pins move on one edge, as on a shared net
  task automatic set_pins(input logic en, input logic rst);
    @(posedge core_clk);
    enable_pin <= en;
    reset_pin  <= rst;
  endtask : set_pins

  // released bus shows inverted values
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : reg_read
endmodule : mers_host_model

`default_nettype wire

/* File: mers_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module mers_top_bench;
  import mers_pkg::*;

  localparam int unsigned SIM_STOP = 1000;

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] data;
    logic [15:0] exp;
  } mers_row_t;

  logic        core_clk;
  logic        rst_n;
  logic        tach;
  logic [2:0]  hall;
  logic [6:0]  fault_det;
  logic        enable_pin;
  logic        reset_pin;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        motor_drive_en;
  logic        brake_active;
  logic        hall_supply_regulator;
  logic        core_clk_en;
  logic        otp_reload;
  logic [5:0]  phase_gate;
  logic [5:0]  pg_first;
  logic [15:0] rd;
  int          num_errors;
  int          comparisons;
  mers_row_t   rows [10];

  mers_top #(.STOP_CYC(SIM_STOP)) u_mers_top (
    .core_clk(core_clk), .rst_n(rst_n), .enable_pin(enable_pin),
    .reset_pin(reset_pin), .tach_pulse_output(tach), .hall_in(hall),
    .fault_det(fault_det), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .motor_drive_en(motor_drive_en), .brake_active(brake_active),
    .hall_supply_regulator(hall_supply_regulator),
    .core_clk_en(core_clk_en), .otp_reload(otp_reload),
    .phase_gate(phase_gate), .tb_tick()
  );

  mers_host_model u_mers_host_model (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .enable_pin(enable_pin),
    .reset_pin(reset_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  function automatic logic pick(input int sel);
    case (sel)
      0:       return motor_drive_en;
      1:       return !motor_drive_en;
      default: return otp_reload;
    endcase
  endfunction : pick

  task automatic wait_for(input int sel, input int max);
    int n;
    n = 0;
    #1;
    while (pick(sel) !== 1'b1 && n < max) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check({15'h0000, pick(sel)}, 16'h0001);
  endtask : wait_for

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0; tach = 1'b0; hall = 3'b001; fault_det = 7'h00;
    num_errors = 0; comparisons = 0;
    rows = '{'{1'b0, 8'h03, 16'h0000, 16'h0010},
             '{1'b0, 8'h00, 16'h0000, 16'h0000},
             '{1'b0, 8'h01, 16'h0000, 16'h0000},
             '{1'b0, 8'h02, 16'h0000, 16'h0000},
             '{1'b0, 8'h2A, 16'h0000, 16'h0018},
             '{1'b0, 8'h7F, 16'h0000, 16'h0000},
             '{1'b1, 8'h01, 16'h0ABC, 16'h0ABC},
             '{1'b1, 8'h02, 16'h0FFF, 16'h0FFF},
             '{1'b1, 8'h7F, 16'hFFFF, 16'h0000},
             '{1'b1, 8'h2A, 16'h007F, 16'h0000}};
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_for(0, 20);
    foreach (rows[i]) begin
      if (rows[i].wr) u_mers_host_model.reg_write(rows[i].addr, rows[i].data);
      u_mers_host_model.reg_read(rows[i].addr, rd);
      check(rd, rows[i].exp);
    end
    @(posedge core_clk) fault_det <= 7'h40;
    repeat (3) @(posedge core_clk);
    fault_det <= 7'h00;
    u_mers_host_model.reg_read(8'h2A, rd);
    check(rd, 16'h0040);
    pg_first = phase_gate;
    @(posedge core_clk) hall <= 3'b011;
    cyc(6);
    check({15'h0000, phase_gate !== 6'h00 && phase_gate !== pg_first}, 16'h0001);
    u_mers_host_model.set_pins(1'b0, 1'b0);
    cyc(100);
    u_mers_host_model.set_pins(1'b1, 1'b0);
    cyc(400);
    check({15'h0000, motor_drive_en}, 16'h0001);
    // withdrawal with braking, tach still turning
    u_mers_host_model.set_pins(1'b0, 1'b0);
    wait_for(1, 330);
    cyc(2);
    check({15'h0000, brake_active}, 16'h0001);
    repeat (6) begin
      repeat (200) @(posedge core_clk);
      tach <= ~tach;
    end
    cyc(SIM_STOP - 20);
    check({15'h0000, hall_supply_regulator}, 16'h0001);
    cyc(60);
    check({14'h0000, hall_supply_regulator, core_clk_en}, 16'h0000);
    u_mers_host_model.reg_write(8'h01, 16'h0555);
    u_mers_host_model.reg_read(8'h01, rd);
    check(rd, 16'h0555);
    // reset during sleep waits for enable
    u_mers_host_model.set_pins(1'b0, 1'b1);
    cyc(20);
    u_mers_host_model.set_pins(1'b1, 1'b1);
    wait_for(2, 60);
    u_mers_host_model.reg_read(8'h01, rd);
    check(rd, 16'h0000);
    cyc(100);
    check({15'h0000, motor_drive_en}, 16'h0000);
    u_mers_host_model.set_pins(1'b1, 1'b0);
    wait_for(0, 20);
    // enable back at once: stop, wait, restart
    u_mers_host_model.set_pins(1'b0, 1'b0);
    cyc(320);
    check({15'h0000, motor_drive_en}, 16'h0000);
    u_mers_host_model.set_pins(1'b1, 1'b0);
    cyc(SIM_STOP - 100);
    check({15'h0000, motor_drive_en}, 16'h0000);
    wait_for(0, 300);
    // coasting stop
    u_mers_host_model.reg_write(8'h00, 16'h0001);
    u_mers_host_model.set_pins(1'b0, 1'b0);
    wait_for(1, 330);
    cyc(2);
    check({15'h0000, brake_active}, 16'h0000);
    u_mers_host_model.set_pins(1'b1, 1'b0);
    wait_for(0, SIM_STOP + 300);
    // reset while running reloads
    u_mers_host_model.set_pins(1'b1, 1'b1);
    wait_for(1, 20);
    wait_for(2, SIM_STOP + 50);
    u_mers_host_model.reg_read(8'h00, rd);
    check(rd, 16'h0000);
    cyc(50);
    check({15'h0000, motor_drive_en}, 16'h0000);
    u_mers_host_model.set_pins(1'b1, 1'b0);
    wait_for(0, 20);
    // polarity change, then shared pin
    u_mers_host_model.reg_write(8'h00, 16'h0002);
    wait_for(1, 20);
    cyc(SIM_STOP + 50);
    check({15'h0000, hall_supply_regulator}, 16'h0000);
    u_mers_host_model.set_pins(1'b0, 1'b0);
    wait_for(0, 60);
    u_mers_host_model.set_pins(1'b1, 1'b1);
    wait_for(1, 330);
    // reset while stopping
    u_mers_host_model.set_pins(1'b1, 1'b0);
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_for(0, 20);
    u_mers_host_model.reg_read(8'h2A, rd);
    check(rd, 16'h0018);
    print_verdict();
  end
endmodule : mers_top_bench

`default_nettype wire
